// >>> load_check_state_report_bank.sv
// read-only load-diagnostic and channel-state report register bank
//
// Overview of operation
// - ground short flag per channel; channel 1 bit 7, channel 2 bit 3.
// - supply short flag per channel; channel 1 bit 6, channel 2 bit 2.
// - open load flag per channel; channel 1 bit 5, channel 2 bit 1.
// - shorted load flag per channel; channel 1 bit 4, channel 2 bit 0.
// - channels 1/2 at 0xA, 3/4 at 0xB, lower channel upper nibble.
// - line-output flags at 0xC, channel 1 bit 3 to 4 bit 0.
// - report registers read-only; fault and line-output registers reset to 0x00.
// - state field three bits: audio_output_active, hi-z, mute, load_check_state, shutdown-auto, shutdown.
// - 0xD holds channel 1 state 7-5, channel 2 4-2, resets 0x24.
// - clean completion flag set only when diagnostics finish fault free.
// - read-only channel 3/4 state register at 0xE resets 0x24.
// - 0xE holds channel 3/4 states and clean flags as 0xD does.
`timescale 1ns/1ps
`include "load_check_state_report_cfg.svh"
module load_check_state_report_bank
	import load_check_state_report_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire rd_req_t                 rd_req,
	input  wire logic [NUM_CH-1:0]       run_done,
	input  wire logic [NUM_CH-1:0]       line_output_check_en,
	input  wire chan_result_t [NUM_CH-1:0] result_in,
	input  wire chan_state_t [NUM_CH-1:0]  chan_state,
	output logic [7:0]                   rdata,
	output logic                         rvalid
);
	chan_result_t [NUM_CH-1:0] held;
	report_state_t st_q;
	report_state_t st_d;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		chan_result_latch u_latch (
			.clk                  (clk),
			.reset                (reset),
			.run_done             (run_done[c]),
			.line_output_check_en (line_output_check_en[c]),
			.result_in            (result_in[c]),
			.result_q             (held[c])
		);
	end

	// pack two channels' faults, lower channel in the upper nibble
	function automatic logic [7:0] pack_faults(input load_fault_t hi,
		input load_fault_t lo);
		logic [7:0] v;
		v = '0;
		v[4+`BIT_GROUND_SHORT] = hi.ground_short_flag;
		v[4+`BIT_SUPPLY_SHORT] = hi.supply_short_flag;
		v[4+`BIT_OPEN_LOAD]    = hi.open_load_flag;
		v[4+`BIT_SHORTED_LOAD] = hi.shorted_load_flag;
		v[`BIT_GROUND_SHORT]   = lo.ground_short_flag;
		v[`BIT_SUPPLY_SHORT]   = lo.supply_short_flag;
		v[`BIT_OPEN_LOAD]      = lo.open_load_flag;
		v[`BIT_SHORTED_LOAD]   = lo.shorted_load_flag;
		return v;
	endfunction : pack_faults

	// pack two channel states and clean flags
	function automatic logic [7:0] pack_state(input chan_state_t s_hi,
		input chan_state_t s_lo, input logic c_hi, input logic c_lo);
		logic [7:0] v;
		v = '0;
		v[`POS_STATE_HI +: 3] = s_hi;
		v[`POS_STATE_LO +: 3] = s_lo;
		v[`POS_CLEAN_HI]      = c_hi;
		v[`POS_CLEAN_LO]      = c_lo;
		return v;
	endfunction : pack_state

	always_comb begin
		st_d = st_q;
		st_d.regs.fault_ch12 = pack_faults(held[0].fault,
			held[1].fault);
		st_d.regs.fault_ch34 = pack_faults(held[2].fault,
			held[3].fault);
		st_d.regs.line_out = {4'h0, held[0].line_output_detect_flag,
			held[1].line_output_detect_flag,
			held[2].line_output_detect_flag,
			held[3].line_output_detect_flag};
		st_d.regs.state_ch12 = pack_state(chan_state[0], chan_state[1],
			held[0].load_check_state_clean_done_flag,
			held[1].load_check_state_clean_done_flag);
		st_d.regs.state_ch34 = pack_state(chan_state[2], chan_state[3],
			held[2].load_check_state_clean_done_flag,
			held[3].load_check_state_clean_done_flag);
		// read decode, no side effect on any flag
		st_d.rvalid = rd_req.rd;
		st_d.rdata  = st_q.rdata;
		if (rd_req.rd) begin
			if (rd_req.addr == `OFS_FAULT_CH12) begin
				st_d.rdata = st_q.regs.fault_ch12;
			end else if (rd_req.addr == `OFS_FAULT_CH34) begin
				st_d.rdata = st_q.regs.fault_ch34;
			end else if (rd_req.addr == `OFS_LINE_OUT) begin
				st_d.rdata = st_q.regs.line_out;
			end else if (rd_req.addr == `OFS_STATE_CH12) begin
				st_d.rdata = st_q.regs.state_ch12;
			end else if (rd_req.addr == `OFS_STATE_CH34) begin
				st_d.rdata = st_q.regs.state_ch34;
			end else begin
				st_d.rdata = `READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q.regs.fault_ch12 <= `RST_FAULT;
			st_q.regs.fault_ch34 <= `RST_FAULT;
			st_q.regs.line_out   <= `RST_LINE_OUT;
			st_q.regs.state_ch12 <= `RST_STATE;
			st_q.regs.state_ch34 <= `RST_STATE;
			st_q.rdata           <= 8'h00;
			st_q.rvalid          <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata  = st_q.rdata;
	assign rvalid = st_q.rvalid;

	sequence s_read_line_out;
		rd_req.rd && rd_req.addr == `OFS_LINE_OUT;
	endsequence
	sequence s_read_fault12;
		rd_req.rd && rd_req.addr == `OFS_FAULT_CH12;
	endsequence

	a_reserved_zero: assert property (
		@(posedge clk) disable iff (reset)
		s_read_line_out |=> rvalid && rdata[7:4] == 4'h0)
		else $error("reserved line-output bits not zero");
	a_fault_ch1_gnd: assert property (
		@(posedge clk) disable iff (reset)
		s_read_fault12 |=> rdata[7] == $past(st_q.regs.fault_ch12[7]))
		else $error("fault read data mismatch");
	a_ch1_ground_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.fault_ch12[7] == $past(held[0].fault.ground_short_flag))
		else $error("channel 1 ground flag misplaced");
	a_ch2_supply_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.fault_ch12[2] == $past(held[1].fault.supply_short_flag))
		else $error("channel 2 supply flag misplaced");
	a_ch3_open_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.fault_ch34[5] == $past(held[2].fault.open_load_flag))
		else $error("channel 3 open flag misplaced");
	a_ch4_short_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.fault_ch34[0] == $past(held[3].fault.shorted_load_flag))
		else $error("channel 4 shorted flag misplaced");
	a_state_ch1_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.state_ch12[7:5] == $past(chan_state[0]))
		else $error("channel 1 state misplaced");
	a_state_ch4_map: assert property (
		@(posedge clk) disable iff (reset)
		##1 st_q.regs.state_ch34[4:2] == $past(chan_state[3]))
		else $error("channel 4 state misplaced");
	a_rvalid_pulse: assert property (
		@(posedge clk) disable iff (reset)
		!rd_req.rd |=> !rvalid)
		else $error("read answer without request");
	a_report_rst_val: assert property (
		@(posedge clk)
		reset |-> st_q.regs.fault_ch12 == `RST_FAULT
			&& st_q.regs.fault_ch34 == `RST_FAULT
			&& st_q.regs.line_out == `RST_LINE_OUT
			&& st_q.regs.state_ch12 == `RST_STATE
			&& st_q.regs.state_ch34 == `RST_STATE)
		else $error("report registers not at reset value");
endmodule : load_check_state_report_bank

// >>> load_check_state_report_cfg.svh
// offsets, field positions, reset values for the diagnostic report bank
`ifndef LOAD_CHECK_STATE_REPORT_CFG_SVH
`define LOAD_CHECK_STATE_REPORT_CFG_SVH
`define OFS_FAULT_CH12      8'h0A
`define OFS_FAULT_CH34      8'h0B
`define OFS_LINE_OUT        8'h0C
`define OFS_STATE_CH12      8'h0D
`define OFS_STATE_CH34      8'h0E
`define RST_FAULT           8'h00
`define RST_LINE_OUT        8'h00
`define RST_STATE           8'h24
`define RST_CH_STATE        3'h1
`define BIT_GROUND_SHORT    3
`define BIT_SUPPLY_SHORT    2
`define BIT_OPEN_LOAD       1
`define BIT_SHORTED_LOAD    0
`define POS_STATE_HI        5
`define POS_STATE_LO        2
`define POS_CLEAN_HI        1
`define POS_CLEAN_LO        0
`define ST_AUDIO_ACTIVE     3'h0
`define ST_HIGH_IMPEDANCE   3'h1
`define ST_MUTED            3'h2
`define ST_LOAD_CHECK       3'h3
`define ST_SHUTDOWN_AUTO    3'h4
`define ST_SHUTDOWN         3'h5
`define READ_UNMAPPED       8'h00
`endif

// >>> load_check_state_report_pkg.sv
// types shared by the diagnostic report bank
package load_check_state_report_pkg;
	typedef enum logic [2:0] {
		audio_output_active,
		high_impedance,
		muted,
		load_check_state,
		protective_shutdown_autorecover,
		protective_shutdown
	} chan_state_t;

	typedef struct packed {
		logic ground_short_flag;
		logic supply_short_flag;
		logic open_load_flag;
		logic shorted_load_flag;
	} load_fault_t;

	typedef struct packed {
		load_fault_t fault;
		logic        line_output_detect_flag;
		logic        load_check_state_clean_done_flag;
	} chan_result_t;

	typedef struct packed {
		logic       rd;
		logic [7:0] addr;
	} rd_req_t;

	typedef struct packed {
		logic [7:0] fault_ch12;
		logic [7:0] fault_ch34;
		logic [7:0] line_out;
		logic [7:0] state_ch12;
		logic [7:0] state_ch34;
	} report_regs_t;

	typedef struct packed {
		report_regs_t regs;
		logic [7:0]   rdata;
		logic         rvalid;
	} report_state_t;
endpackage : load_check_state_report_pkg

// >>> chan_result_latch.sv
// per-channel result holder, updated only at end of a diagnostic run
`timescale 1ns/1ps
`include "load_check_state_report_cfg.svh"
module chan_result_latch
	import load_check_state_report_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         run_done,
	input  wire logic         line_output_check_en,
	input  wire chan_result_t result_in,
	output chan_result_t      result_q
);
	typedef struct packed {
		chan_result_t res;
	} latch_state_t;

	latch_state_t st_q;
	latch_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (run_done) begin
			st_d.res = result_in;
			// line-output flag only evaluated when enabled
			st_d.res.line_output_detect_flag =
				result_in.line_output_detect_flag & line_output_check_en;
			// clean completion only when no fault found
			st_d.res.load_check_state_clean_done_flag = result_in.load_check_state_clean_done_flag
				& ~(|result_in.fault);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign result_q = st_q.res;

	a_clean_no_fault: assert property (
		@(posedge clk) disable iff (reset)
		st_q.res.load_check_state_clean_done_flag |-> ~(|st_q.res.fault))
		else $error("clean flag set with a fault present");
	a_hold_no_run: assert property (
		@(posedge clk) disable iff (reset)
		!$past(run_done) |-> $stable(st_q.res))
		else $error("result changed without a run");
	a_lo_needs_en: assert property (
		@(posedge clk) disable iff (reset)
		$past(run_done) && !$past(line_output_check_en)
		|-> !st_q.res.line_output_detect_flag)
		else $error("line-output flag set while check disabled");
endmodule : chan_result_latch

// >>> load_check_state_host_model.sv
// host model reading the report bank over the strobe port
`timescale 1ns/1ps
module load_check_state_host_model
	import load_check_state_report_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid,
	output rd_req_t         rd_req,
	output logic [3:0]      line_output_check_en
);
	initial begin
		rd_req = '0;
		line_output_check_en = 4'h0;
	end
	// enables set ahead of the run that evaluates them
	task automatic set_enables(input logic [3:0] e);
		@(posedge clk);
		#1;
		line_output_check_en = e;
	endtask : set_enables
	// one-cycle strobe, answer taken right after the taking edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(posedge clk);
		#1;
		rd_req.rd = 1'b1;
		rd_req.addr = a;
		@(posedge clk);
		#1;
		rd_req.rd = 1'b0;
		rd_req.addr = ~a;
		ok = rvalid;
		d = rdata;
	endtask : read_reg
endmodule : load_check_state_host_model

// >>> tb.sv
// self-checking bench for the diagnostic report bank
`timescale 1ns/1ps
module tb import load_check_state_report_pkg::*;;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %0t: got %h expected %h", $time, g, e); end end
	logic                clk;
	logic                reset;
	rd_req_t             rd_req;
	logic [3:0]          run_done;
	logic [3:0]          lo_en;
	chan_result_t [3:0]  result_in;
	chan_state_t [3:0]   chan_state;
	logic [7:0]          rdata;
	logic                rvalid;
	chan_result_t        held [4];
	int                  failures;
	int                  n_checks;

	load_check_state_report_bank #(.NUM_CH(4)) uut (.clk(clk), .reset(reset),
		.rd_req(rd_req), .run_done(run_done),
		.line_output_check_en(lo_en), .result_in(result_in),
		.chan_state(chan_state), .rdata(rdata), .rvalid(rvalid));
	load_check_state_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid),
		.rd_req(rd_req), .line_output_check_en(lo_en));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [7:0] expect_reg(input logic [7:0] a);
		case (a)
			8'h0A: return {held[0].fault, held[1].fault};
			8'h0B: return {held[2].fault, held[3].fault};
			8'h0C: return {4'h0, held[0].line_output_detect_flag,
				held[1].line_output_detect_flag,
				held[2].line_output_detect_flag,
				held[3].line_output_detect_flag};
			8'h0D: return {chan_state[0], chan_state[1],
				held[0].load_check_state_clean_done_flag, held[1].load_check_state_clean_done_flag};
			8'h0E: return {chan_state[2], chan_state[3],
				held[2].load_check_state_clean_done_flag, held[3].load_check_state_clean_done_flag};
			default: return 8'h00;
		endcase
	endfunction : expect_reg

	task automatic check_all();
		logic [7:0] d;
		logic       ok;
		for (int a = 9; a <= 15; a++) begin
			repeat (2) begin
				host.read_reg(8'(a), d, ok);
				`CHK(ok, 1'b1)
				`CHK(d, expect_reg(8'(a)))
			end
		end
	endtask : check_all

	task automatic run_load_check_state(input logic [3:0] m, input logic [23:0] r,
		input int i);
		chan_result_t h;
		@(posedge clk);
		#1;
		result_in = r;
		for (int c = 0; c < 4; c++) begin
			chan_state[c] = chan_state_t'(3'((i + c) % 6));
			h = result_in[c];
			h.line_output_detect_flag &= lo_en[c];
			if (|h.fault)
				h.load_check_state_clean_done_flag = 1'b0;
			if (m[c])
				held[c] = h;
		end
		run_done = m;
		@(posedge clk);
		#1;
		run_done = 4'h0;
		result_in = ~r;
	endtask : run_load_check_state

	task automatic reset_dut();
		reset = 1'b1;
		for (int c = 0; c < 4; c++) begin
			chan_state[c] = high_impedance;
			held[c] = '0;
		end
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
	endtask : reset_dut

	task complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#400000;
		failures++;
		complete_run();
	end

	initial begin
		failures = 0;
		n_checks = 0;
		run_done = 4'h0;
		result_in = '0;
		void'($urandom(32'h98D2));
		reset_dut();
		check_all();
		host.set_enables(4'hA);
		run_load_check_state(4'hF, 24'hFFFFFF, 0);
		check_all();
		run_load_check_state(4'hF, 24'h041041, 1);
		check_all();
		for (int i = 2; i < 12; i++) begin
			host.set_enables(4'($urandom));
			run_load_check_state(4'($urandom), 24'($urandom), i);
			check_all();
		end
		reset_dut();
		check_all();
		complete_run();
	end
endmodule : tb
